// ### portcd_mux_map.vh
// constants for the port c/d alternate-function override logic
// assumes inclusion by the mux modules only
`ifndef PORTCD_MUX_MAP_VH
`define PORTCD_MUX_MAP_VH
`define PORT_WIDTH         8
`define PORT_RESET_VALUE   8'h00
`define PC_CHANGE_BASE     16
`define PD_CHANGE_BASE     24
`define PC_OSC_OUT_BIT     7
`define PC_OSC_IN_BIT      6
`define PC_TDI_BIT         5
`define PC_TDO_BIT         4
`define PC_TMS_BIT         3
`define PC_TCK_BIT         2
`define PC_SDA_BIT         1
`define PC_SCL_BIT         0
`define PD_T2A_BIT         7
`define PD_T2B_BIT         6
`define PD_T1A_BIT         5
`define PD_T1B_BIT         4
`define PD_EXTERNAL_IRQ_1_IN_BIT        3
`define PD_EXTERNAL_IRQ_0_IN_BIT        2
`define PD_TX0_BIT         1
`define PD_RX0_BIT         0
`endif

// ### pin_override_cell.v
// one port pin: chooses between register settings and peripheral overrides
// assumes all inputs share clk; pad input already synchronised upstream
`timescale 1ns/1ps
`default_nettype none
module pin_override_cell (
   // register side
   input  wire pull_global_dis,
   input  wire dir_reg,
   input  wire out_reg,
   // override controls
   input  wire pullup_override_enable,
   input  wire pullup_override_value,
   input  wire direction_override_enable,
   input  wire direction_override_value,
   input  wire pin_value_override_enable,
   input  wire pin_value_override_value,
   input  wire input_enable_override_enable,
   input  wire input_enable_override_value,
   input  wire sleep_in_dis,
   // resolved pin controls
   output wire pull_en,
   output wire drive_en,
   output wire drive_val,
   output wire in_en
);
   wire pull_reg = out_reg & ~dir_reg & ~pull_global_dis;
   assign pull_en   = pullup_override_enable ?
                      pullup_override_value : pull_reg;
   assign drive_en  = direction_override_enable ?
                      direction_override_value : dir_reg;
   assign drive_val = pin_value_override_enable ?
                      pin_value_override_value : out_reg;
   assign in_en     = input_enable_override_enable ?
                      input_enable_override_value : ~sleep_in_dis;
endmodule
`default_nettype wire

// ### portcd_alt_mux.v
// port c and port d alternate-function override and input routing
// assumes peripheral controls are on clk; pad inputs are asynchronous
// How it works
// - global pull-up disable kills register pull-ups
// - pc7 oscillator output forces input, no pull
// - pc6 oscillator input forces input, no pull
// - test port holds pc5/pc3/pc2 inputs, pulled up
// - pc4 drives test data out while shifting
// - two-wire forces pc1/pc0 to input with sda/scl as pad values, pull gated
// - pc pins are change sources 16-23
// - pd pins are change sources 24-31
// - pd7 drives timer2 compare a when output
// - pd6 drives timer2 compare b when output
// - pd6 feeds timer1 capture input
// - pd5 drives timer1 compare a when output
// - pd4 drives timer1 compare b when output
// - pd4 carries usart1 sync clock both ways
// - pd0 feeds timer3 count input
// - pd3/pd2 feed external interrupts 1/0
// - pd3/pd2 usart1, pd1/pd0 usart0 lines
`timescale 1ns/1ps
`default_nettype none
`include "portcd_mux_map.vh"
module portcd_alt_mux #(
   parameter W = `PORT_WIDTH
) (
   // clock and reset
   input  wire         clk,
   input  wire         reset_n,
   input  wire         clk_en,
   // port registers
   input  wire         pullup_global_disable,
   input  wire [W-1:0] port_c_out,
   input  wire [W-1:0] port_c_dir,
   input  wire [W-1:0] port_d_out,
   input  wire [W-1:0] port_d_dir,
   input  wire         sleep_input_disable,
   // oscillator and test port
   input  wire         async_timer_clock_select,
   input  wire         external_osc_clock_select,
   input  wire         test_port_enable,
   input  wire         instruction_shift_state,
   input  wire         data_shift_state,
   input  wire         test_data_out,
   // two-wire
   input  wire         two_wire_enable,
   input  wire         sda_out,
   input  wire         scl_out,
   // pin change
   input  wire         port_c_change_group_enable,
   input  wire         port_d_change_group_enable,
   input  wire [W-1:0] port_c_change_mask,
   input  wire [W-1:0] port_d_change_mask,
   // timers
   input  wire         timer2_compare_a_en,
   input  wire         timer2_compare_a_out,
   input  wire         timer2_compare_b_en,
   input  wire         timer2_compare_b_out,
   input  wire         timer1_compare_a_en,
   input  wire         timer1_compare_a_out,
   input  wire         timer1_compare_b_en,
   input  wire         timer1_compare_b_out,
   // usarts and interrupts
   input  wire         usart1_sync_mode,
   input  wire         usart1_sync_clock_out,
   input  wire         usart1_tx_enable,
   input  wire         usart1_rx_enable,
   input  wire         usart1_transmit,
   input  wire         usart0_tx_enable,
   input  wire         usart0_rx_enable,
   input  wire         usart0_transmit,
   input  wire         external_irq_0_enable,
   input  wire         external_irq_1_enable,
   // pads
   input  wire [W-1:0] port_c_pad_in,
   input  wire [W-1:0] port_d_pad_in,
   output wire [W-1:0] port_c_pad_out,
   output wire [W-1:0] port_c_pad_oe,
   output wire [W-1:0] port_c_pull_en,
   output wire [W-1:0] port_d_pad_out,
   output wire [W-1:0] port_d_pad_oe,
   output wire [W-1:0] port_d_pull_en,
   // routed inputs
   output reg  [31:16] pin_change_source,
   output reg  [W-1:0] port_c_pin_value,
   output reg  [W-1:0] port_d_pin_value,
   output reg          timer_osc_input,
   output wire         timer_osc_output,
   output reg          test_data_in,
   output reg          test_mode_select,
   output reg          test_clock,
   output reg          sda_in,
   output reg          scl_in,
   output reg          timer1_capture_in,
   output reg          usart1_sync_clock_in,
   output reg          timer3_count_in,
   output reg          external_irq_0_in,
   output reg          external_irq_1_in,
   output reg          usart1_receive,
   output reg          usart0_receive
);
   reg  [W-1:0] c_meta_q, c_sync_q, d_meta_q, d_sync_q;
   reg  [W-1:0] c_pullup_override_enable, c_pullup_override_value, c_direction_override_enable, c_direction_override_value, c_pin_value_override_enable, c_pin_value_override_value;
   reg  [W-1:0] c_dioe, c_diov;
   reg  [W-1:0] d_pullup_override_enable, d_pullup_override_value, d_direction_override_enable, d_direction_override_value, d_pin_value_override_enable, d_pin_value_override_value;
   reg  [W-1:0] d_dioe, d_diov;
   wire [W-1:0] c_ie, d_ie, c_oe_w, d_oe_w;
   wire         as_ext = async_timer_clock_select & external_osc_clock_select;
   wire         tp = test_port_enable;
   wire         twe = two_wire_enable;
   wire [W-1:0] c_chg = port_c_change_mask &
                        {W{port_c_change_group_enable}};
   wire [W-1:0] d_chg = port_d_change_mask &
                        {W{port_d_change_group_enable}};
   wire [W-1:0] c_in  = c_sync_q & c_ie;
   wire [W-1:0] d_in  = d_sync_q & d_ie;

   always @* begin
      c_pullup_override_enable = {W{1'b0}};
      c_pullup_override_value = {W{1'b0}};
      c_direction_override_enable = {W{1'b0}};
      c_direction_override_value = {W{1'b0}};
      c_pin_value_override_enable = {W{1'b0}};
      c_pin_value_override_value = {W{1'b0}};
      c_dioe = c_chg;
      c_diov = {W{1'b1}};
      // oscillator pins
      c_pullup_override_enable[`PC_OSC_OUT_BIT] = as_ext;
      c_direction_override_enable[`PC_OSC_OUT_BIT] = as_ext;
      c_dioe[`PC_OSC_OUT_BIT] = as_ext | c_chg[`PC_OSC_OUT_BIT];
      c_diov[`PC_OSC_OUT_BIT] = as_ext ? async_timer_clock_select
                                       : 1'b1;
      c_pullup_override_enable[`PC_OSC_IN_BIT]  = async_timer_clock_select;
      c_direction_override_enable[`PC_OSC_IN_BIT]  = async_timer_clock_select;
      c_dioe[`PC_OSC_IN_BIT]  = async_timer_clock_select |
                                c_chg[`PC_OSC_IN_BIT];
      c_diov[`PC_OSC_IN_BIT]  = async_timer_clock_select ?
         (external_osc_clock_select | async_timer_clock_select)
         : 1'b1;
      // test port pins
      c_pullup_override_enable[`PC_TDI_BIT] = tp;
      c_pullup_override_value[`PC_TDI_BIT] = 1'b1;
      c_direction_override_enable[`PC_TDI_BIT] = tp;
      c_dioe[`PC_TDI_BIT] = tp | c_chg[`PC_TDI_BIT];
      c_pullup_override_enable[`PC_TMS_BIT] = tp;
      c_pullup_override_value[`PC_TMS_BIT] = 1'b1;
      c_direction_override_enable[`PC_TMS_BIT] = tp;
      c_dioe[`PC_TMS_BIT] = tp | c_chg[`PC_TMS_BIT];
      c_pullup_override_enable[`PC_TCK_BIT] = tp;
      c_pullup_override_value[`PC_TCK_BIT] = 1'b1;
      c_direction_override_enable[`PC_TCK_BIT] = tp;
      c_dioe[`PC_TCK_BIT] = tp | c_chg[`PC_TCK_BIT];
      c_pullup_override_enable[`PC_TDO_BIT] = tp;
      c_pullup_override_value[`PC_TDO_BIT] = 1'b1;
      c_direction_override_enable[`PC_TDO_BIT] = tp;
      c_direction_override_value[`PC_TDO_BIT] = instruction_shift_state |
                            data_shift_state;
      c_pin_value_override_enable[`PC_TDO_BIT] = tp;
      c_pin_value_override_value[`PC_TDO_BIT] = test_data_out;
      c_dioe[`PC_TDO_BIT] = tp | c_chg[`PC_TDO_BIT];
      // two-wire pins
      c_pullup_override_enable[`PC_SDA_BIT] = twe;
      c_pullup_override_value[`PC_SDA_BIT] = port_c_out[`PC_SDA_BIT] &
                            ~pullup_global_disable;
      c_direction_override_enable[`PC_SDA_BIT] = twe;
      c_pin_value_override_enable[`PC_SDA_BIT] = twe;
      c_pin_value_override_value[`PC_SDA_BIT] = sda_out;
      c_pullup_override_enable[`PC_SCL_BIT] = twe;
      c_pullup_override_value[`PC_SCL_BIT] = port_c_out[`PC_SCL_BIT] &
                            ~pullup_global_disable;
      c_direction_override_enable[`PC_SCL_BIT] = twe;
      c_pin_value_override_enable[`PC_SCL_BIT] = twe;
      c_pin_value_override_value[`PC_SCL_BIT] = scl_out;
   end

   always @* begin
      d_pullup_override_enable = {W{1'b0}};
      d_pullup_override_value = {W{1'b0}};
      d_direction_override_enable = {W{1'b0}};
      d_direction_override_value = {W{1'b0}};
      d_pin_value_override_enable = {W{1'b0}};
      d_pin_value_override_value = {W{1'b0}};
      d_dioe = d_chg;
      d_diov = {W{1'b1}};
      // compare outputs only reach the pad while dir bit is output
      d_pin_value_override_enable[`PD_T2A_BIT] = timer2_compare_a_en;
      d_pin_value_override_value[`PD_T2A_BIT] = timer2_compare_a_out;
      d_pin_value_override_enable[`PD_T2B_BIT] = timer2_compare_b_en;
      d_pin_value_override_value[`PD_T2B_BIT] = timer2_compare_b_out;
      d_pin_value_override_enable[`PD_T1A_BIT] = timer1_compare_a_en;
      d_pin_value_override_value[`PD_T1A_BIT] = timer1_compare_a_out;
      d_pin_value_override_enable[`PD_T1B_BIT] = timer1_compare_b_en |
                            usart1_sync_mode;
      d_pin_value_override_value[`PD_T1B_BIT] = usart1_sync_mode ? usart1_sync_clock_out
                            : timer1_compare_b_out;
      // usart lines
      d_pullup_override_enable[`PD_EXTERNAL_IRQ_1_IN_BIT] = usart1_tx_enable;
      d_direction_override_enable[`PD_EXTERNAL_IRQ_1_IN_BIT] = usart1_tx_enable;
      d_direction_override_value[`PD_EXTERNAL_IRQ_1_IN_BIT] = 1'b1;
      d_pin_value_override_enable[`PD_EXTERNAL_IRQ_1_IN_BIT] = usart1_tx_enable;
      d_pin_value_override_value[`PD_EXTERNAL_IRQ_1_IN_BIT] = usart1_transmit;
      d_dioe[`PD_EXTERNAL_IRQ_1_IN_BIT] = external_irq_1_enable | d_chg[`PD_EXTERNAL_IRQ_1_IN_BIT];
      d_pullup_override_enable[`PD_EXTERNAL_IRQ_0_IN_BIT] = usart1_rx_enable;
      d_pullup_override_value[`PD_EXTERNAL_IRQ_0_IN_BIT] = port_d_out[`PD_EXTERNAL_IRQ_0_IN_BIT] &
                             ~pullup_global_disable;
      d_direction_override_enable[`PD_EXTERNAL_IRQ_0_IN_BIT] = usart1_rx_enable;
      d_dioe[`PD_EXTERNAL_IRQ_0_IN_BIT] = external_irq_0_enable | d_chg[`PD_EXTERNAL_IRQ_0_IN_BIT];
      d_pullup_override_enable[`PD_TX0_BIT]  = usart0_tx_enable;
      d_direction_override_enable[`PD_TX0_BIT]  = usart0_tx_enable;
      d_direction_override_value[`PD_TX0_BIT]  = 1'b1;
      d_pin_value_override_enable[`PD_TX0_BIT]  = usart0_tx_enable;
      d_pin_value_override_value[`PD_TX0_BIT]  = usart0_transmit;
      d_pullup_override_enable[`PD_RX0_BIT]  = usart0_rx_enable;
      d_pullup_override_value[`PD_RX0_BIT]  = port_d_out[`PD_RX0_BIT] &
                             ~pullup_global_disable;
      d_direction_override_enable[`PD_RX0_BIT]  = usart0_rx_enable;
   end

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_pin
         pin_override_cell u_c (
            .pull_global_dis             (pullup_global_disable),
            .dir_reg                     (port_c_dir[i]),
            .out_reg                     (port_c_out[i]),
            .pullup_override_enable      (c_pullup_override_enable[i]),
            .pullup_override_value       (c_pullup_override_value[i]),
            .direction_override_enable   (c_direction_override_enable[i]),
            .direction_override_value    (c_direction_override_value[i]),
            .pin_value_override_enable   (c_pin_value_override_enable[i]),
            .pin_value_override_value    (c_pin_value_override_value[i]),
            .input_enable_override_enable(c_dioe[i]),
            .input_enable_override_value (c_diov[i]),
            .sleep_in_dis                (sleep_input_disable),
            .pull_en                     (port_c_pull_en[i]),
            .drive_en                    (c_oe_w[i]),
            .drive_val                   (port_c_pad_out[i]),
            .in_en                       (c_ie[i])
         );
         pin_override_cell u_d (
            .pull_global_dis             (pullup_global_disable),
            .dir_reg                     (port_d_dir[i]),
            .out_reg                     (port_d_out[i]),
            .pullup_override_enable      (d_pullup_override_enable[i]),
            .pullup_override_value       (d_pullup_override_value[i]),
            .direction_override_enable   (d_direction_override_enable[i]),
            .direction_override_value    (d_direction_override_value[i]),
            .pin_value_override_enable   (d_pin_value_override_enable[i]),
            .pin_value_override_value    (d_pin_value_override_value[i]),
            .input_enable_override_enable(d_dioe[i]),
            .input_enable_override_value (d_diov[i]),
            .sleep_in_dis                (sleep_input_disable),
            .pull_en                     (port_d_pull_en[i]),
            .drive_en                    (d_oe_w[i]),
            .drive_val                   (port_d_pad_out[i]),
            .in_en                       (d_ie[i])
         );
      end
   endgenerate

   assign port_c_pad_oe = c_oe_w;
   assign port_d_pad_oe = d_oe_w;
   // oscillator output is analog; digital side only mirrors enable
   assign timer_osc_output = as_ext;

   // pad synchronisers, then registered routing
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         c_meta_q             <= `PORT_RESET_VALUE;
         c_sync_q             <= `PORT_RESET_VALUE;
         d_meta_q             <= `PORT_RESET_VALUE;
         d_sync_q             <= `PORT_RESET_VALUE;
         pin_change_source    <= 16'h0000;
         port_c_pin_value     <= `PORT_RESET_VALUE;
         port_d_pin_value     <= `PORT_RESET_VALUE;
         timer_osc_input      <= 1'b0;
         test_data_in         <= 1'b0;
         test_mode_select     <= 1'b0;
         test_clock           <= 1'b0;
         sda_in               <= 1'b0;
         scl_in               <= 1'b0;
         timer1_capture_in    <= 1'b0;
         usart1_sync_clock_in <= 1'b0;
         timer3_count_in      <= 1'b0;
         external_irq_0_in    <= 1'b0;
         external_irq_1_in    <= 1'b0;
         usart1_receive       <= 1'b0;
         usart0_receive       <= 1'b0;
      end else if (clk_en) begin
         c_meta_q             <= port_c_pad_in;
         c_sync_q             <= c_meta_q;
         d_meta_q             <= port_d_pad_in;
         d_sync_q             <= d_meta_q;
         pin_change_source    <= {d_in, c_in};
         port_c_pin_value     <= c_in;
         port_d_pin_value     <= d_in;
         timer_osc_input      <= c_sync_q[`PC_OSC_IN_BIT] &
                                 async_timer_clock_select;
         test_data_in         <= c_sync_q[`PC_TDI_BIT] & tp;
         test_mode_select     <= c_sync_q[`PC_TMS_BIT] & tp;
         test_clock           <= c_sync_q[`PC_TCK_BIT] & tp;
         sda_in               <= c_sync_q[`PC_SDA_BIT];
         scl_in               <= c_sync_q[`PC_SCL_BIT];
         timer1_capture_in    <= d_in[`PD_T2B_BIT];
         usart1_sync_clock_in <= d_in[`PD_T1B_BIT] & usart1_sync_mode &
                                 ~port_d_dir[`PD_T1B_BIT];
         timer3_count_in      <= d_in[`PD_RX0_BIT];
         external_irq_0_in    <= d_in[`PD_EXTERNAL_IRQ_0_IN_BIT];
         external_irq_1_in    <= d_in[`PD_EXTERNAL_IRQ_1_IN_BIT];
         usart1_receive       <= d_in[`PD_EXTERNAL_IRQ_0_IN_BIT];
         usart0_receive       <= d_in[`PD_RX0_BIT];
      end
   end
endmodule
`default_nettype wire

// ### board_pins.sv
// board side of one port: drives or pulls up released pads, else lets them float
// assumes one clock; undriven pads with no pull wobble every cycle
`timescale 1ns/1ps
`default_nettype none
module board_pins (
   // clock
   input  wire logic       clk,
   // device pad controls and board drivers
   input  wire logic [7:0] pad_out,
   input  wire logic [7:0] pad_oe,
   input  wire logic [7:0] pull_en,
   input  wire logic [7:0] ext_val,
   input  wire logic [7:0] ext_en,
   // level seen by the device
   output logic      [7:0] pad_in
);
   logic [7:0] wobble_q = 8'hA5;
   always @(posedge clk) wobble_q <= ~wobble_q;
   // device drive wins, then board, then pull-up, else floating
   always @* pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
      | (~pad_oe & ~ext_en & (pull_en | wobble_q));
endmodule
`default_nettype wire

// ### portcd_alt_mux_properties.sv
// pad override and input routing assertions for the port c/d block
// assumes pad inputs settle between clock edges
`timescale 1ns/1ps
`default_nettype none
module portcd_alt_mux_props #(
   parameter W = 8
) (
   // clock and controls
   input wire logic          clk,
   input wire logic          reset_n,
   input wire logic          clk_en,
   input wire logic          sleep_input_disable,
   input wire logic          pullup_global_disable,
   input wire logic [W-1:0]  port_d_out,
   input wire logic [W-1:0]  port_d_dir,
   input wire logic          async_timer_clock_select,
   input wire logic          external_osc_clock_select,
   input wire logic          test_port_enable,
   input wire logic          instruction_shift_state,
   input wire logic          data_shift_state,
   input wire logic          test_data_out,
   // pads and routed inputs
   input wire logic [W-1:0]  port_c_pad_in,
   input wire logic [W-1:0]  port_d_pad_in,
   input wire logic [W-1:0]  port_c_pad_out,
   input wire logic [W-1:0]  port_c_pad_oe,
   input wire logic [W-1:0]  port_c_pull_en,
   input wire logic [W-1:0]  port_d_pull_en,
   input wire logic [31:16]  pin_change_source,
   input wire logic          timer_osc_output
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence settled;
      (reset_n && clk_en && !sleep_input_disable) [*4];
   endsequence
   a_register_pull: assert property (
      port_d_pull_en[7:4] == (port_d_out[7:4] & ~port_d_dir[7:4]
      & {4{~pullup_global_disable}})) else $error("pd pull-up wrong");
   a_osc_out_pin: assert property (
      async_timer_clock_select && external_osc_clock_select |->
      !port_c_pad_oe[7] && !port_c_pull_en[7]) else $error("pc7 not freed");
   a_osc_drive: assert property (
      timer_osc_output == (async_timer_clock_select
      && external_osc_clock_select)) else $error("osc output wrong");
   a_osc_in_pin: assert property (
      async_timer_clock_select |-> !port_c_pad_oe[6] && !port_c_pull_en[6])
      else $error("pc6 not freed");
   a_test_inputs: assert property (
      test_port_enable |-> port_c_pull_en[5] && port_c_pull_en[3]
      && port_c_pull_en[2] && !(|(port_c_pad_oe & 8'h2C)))
      else $error("test inputs wrong");
   a_test_output: assert property (
      test_port_enable |-> port_c_pull_en[4] && port_c_pad_out[4] ==
      test_data_out && port_c_pad_oe[4] == (instruction_shift_state ||
      data_shift_state)) else $error("test output wrong");
   a_change_sync: assert property (
      settled |-> pin_change_source == {$past(port_d_pad_in, 3),
      $past(port_c_pad_in, 3)}) else $error("change source wrong");
   a_change_hold: assert property (
      !clk_en |=> $stable(pin_change_source)) else $error("not held");
endmodule
bind portcd_alt_mux portcd_alt_mux_props #(.W(W)) props_i (.*);
`default_nettype wire

// ### testbench.sv
// random bench for the port c/d override block with a reference model
// assumes board models on both ports and the bound checker
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk, reset_n, clk_en, pullup_global_disable, sleep_input_disable;
   logic [7:0] port_c_out, port_c_dir, port_d_out, port_d_dir;
   logic async_timer_clock_select, external_osc_clock_select;
   logic test_port_enable, instruction_shift_state, data_shift_state;
   logic test_data_out, two_wire_enable, sda_out, scl_out;
   logic port_c_change_group_enable, port_d_change_group_enable;
   logic [7:0] port_c_change_mask, port_d_change_mask;
   logic timer2_compare_a_en, timer2_compare_a_out, timer2_compare_b_en;
   logic timer2_compare_b_out, timer1_compare_a_en, timer1_compare_a_out;
   logic timer1_compare_b_en, timer1_compare_b_out, usart1_sync_mode;
   logic usart1_sync_clock_out, usart1_tx_enable, usart1_rx_enable;
   logic usart1_transmit, usart0_tx_enable, usart0_rx_enable;
   logic usart0_transmit, external_irq_0_enable, external_irq_1_enable;
   wire [7:0] port_c_pad_in, port_d_pad_in, port_c_pad_out, port_c_pad_oe;
   wire [7:0] port_c_pull_en, port_d_pad_out, port_d_pad_oe, port_d_pull_en;
   wire [7:0] port_c_pin_value, port_d_pin_value;
   wire [31:16] pin_change_source;
   wire timer_osc_input, timer_osc_output, test_data_in, test_mode_select;
   wire test_clock, sda_in, scl_in, timer1_capture_in, usart1_sync_clock_in;
   wire timer3_count_in, external_irq_0_in, external_irq_1_in;
   wire usart1_receive, usart0_receive;
   logic [7:0] c_ext, c_ext_en, d_ext, d_ext_en;
   logic [31:0] seed;
   int failures, samples_checked, cycles, s1, s2, pv, rt;
   portcd_alt_mux portcd_alt_mux_i (.*);
   board_pins pins_c_i (.clk(clk), .pad_out(port_c_pad_out),
      .pad_oe(port_c_pad_oe), .pull_en(port_c_pull_en), .ext_val(c_ext),
      .ext_en(c_ext_en), .pad_in(port_c_pad_in));
   board_pins pins_d_i (.clk(clk), .pad_out(port_d_pad_out),
      .pad_oe(port_d_pad_oe), .pull_en(port_d_pull_en), .ext_val(d_ext),
      .ext_en(d_ext_en), .pad_in(port_d_pad_in));
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      for (int i = 0; i < 32; i++) v = {v[30:0], v[31]^v[21]^v[1]^v[0]};
      return v;
   endfunction
   function automatic logic [15:0] in_enable();
      logic [15:0] e;
      e = {port_d_change_mask & {8{port_d_change_group_enable}},
         port_c_change_mask & {8{port_c_change_group_enable}}};
      e[11:10] = e[11:10] | {external_irq_1_enable, external_irq_0_enable};
      e[7:2] = e[7:2] | {async_timer_clock_select & external_osc_clock_select,
         async_timer_clock_select, {4{test_port_enable}}};
      return sleep_input_disable ? e : 16'hFFFF;
   endfunction
   // two sync stages, then the gated pin value
   always @(posedge clk or negedge reset_n)
      if (!reset_n) begin
         {s1, s2, pv, rt} <= 128'h0;
      end else if (clk_en) begin
         s1 <= {port_d_pad_in, port_c_pad_in};
         s2 <= s1;
         pv <= s2 & in_enable();
         rt <= {s2[6] & async_timer_clock_select,
            s2[5] & test_port_enable, s2[3:2] & {2{test_port_enable}},
            s2[1:0], usart1_sync_mode & ~port_d_dir[4]};
      end
   task automatic compare(input logic [47:0] got, input logic [47:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h, want %h", $time, got, exp);
      end
   endtask
   task automatic check_all();
      logic [7:0] rp, co, ce, cp, dq, de, dp;
      rp = ~{8{pullup_global_disable}};
      {co, ce, dq, de} = {port_c_out, port_c_dir, port_d_out, port_d_dir};
      cp = co & ~ce & rp;
      dp = dq & ~de & rp;
      if (async_timer_clock_select) begin
         {ce[6], cp[6]} = 2'h0;
         if (external_osc_clock_select) {ce[7], cp[7]} = 2'h0;
      end
      if (test_port_enable) begin
         {ce[5], ce[3:2], cp[5:2]} = 7'h0F;
         {ce[4], co[4]} = {instruction_shift_state | data_shift_state,
            test_data_out};
      end
      if (two_wire_enable)
         {ce[1:0], co[1:0], cp[1:0]} = {2'h0, sda_out, scl_out,
            port_c_out[1:0] & rp[1:0]};
      if (timer2_compare_a_en) dq[7] = timer2_compare_a_out;
      if (timer2_compare_b_en) dq[6] = timer2_compare_b_out;
      if (timer1_compare_a_en) dq[5] = timer1_compare_a_out;
      if (timer1_compare_b_en) dq[4] = timer1_compare_b_out;
      if (usart1_sync_mode) dq[4] = usart1_sync_clock_out;
      if (usart1_tx_enable)
         {de[3], dq[3], dp[3]} = {1'h1, usart1_transmit, 1'h0};
      if (usart1_rx_enable) {de[2], dp[2]} = {1'h0, dq[2] & rp[2]};
      if (usart0_tx_enable)
         {de[1], dq[1], dp[1]} = {1'h1, usart0_transmit, 1'h0};
      if (usart0_rx_enable) {de[0], dp[0]} = {1'h0, dq[0] & rp[0]};
      compare({port_c_pad_oe, port_c_pad_out, port_c_pull_en,
         port_d_pad_oe, port_d_pad_out, port_d_pull_en},
         {ce, co, cp, de, dq, dp});
      compare(48'({pin_change_source, port_d_pin_value,
         port_c_pin_value}), 48'({pv[15:0], pv[15:0]}));
      compare(48'({timer1_capture_in, timer3_count_in}),
         48'({pv[14], pv[8]}));
      compare(48'({timer_osc_input, test_data_in, test_mode_select,
         test_clock, sda_in, scl_in, usart1_sync_clock_in}),
         48'({rt[6:1], pv[12] & rt[0]}));
      compare(48'({external_irq_1_in, external_irq_0_in,
         usart1_receive, usart0_receive}), 48'({pv[11:10], pv[10], pv[8]}));
   endtask
   task automatic drive();
      logic [31:0] r0, r1, r2, r3;
      r0 = lfsr(seed);
      r1 = lfsr(r0);
      r2 = lfsr(r1);
      r3 = lfsr(r2);
      seed = r3;
      {port_c_out, port_c_dir, port_d_out, port_d_dir} <= r0;
      {port_c_change_mask, port_d_change_mask, c_ext, d_ext} <= r1;
      {c_ext_en, d_ext_en, timer2_compare_a_en, timer2_compare_a_out,
         timer2_compare_b_en, timer2_compare_b_out, timer1_compare_a_en,
         timer1_compare_a_out, timer1_compare_b_en, timer1_compare_b_out,
         usart1_sync_mode, usart1_sync_clock_out, usart1_tx_enable,
         usart1_rx_enable, usart1_transmit, usart0_tx_enable,
         usart0_rx_enable, usart0_transmit} <= r2;
      {pullup_global_disable, async_timer_clock_select,
         external_osc_clock_select, test_port_enable, instruction_shift_state,
         data_shift_state, test_data_out, two_wire_enable, sda_out, scl_out,
         port_c_change_group_enable, port_d_change_group_enable,
         external_irq_0_enable, external_irq_1_enable} <= r3[13:0];
      clk_en <= |r3[15:14];
      sleep_input_disable <= &r3[18:16];
   endtask
   task automatic tally_and_finish();
      if (failures == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         failures++;
         tally_and_finish();
      end
   end
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      seed = 32'h3D7F;
      reset_n = 1'h0;
      drive();
      repeat (12) @(negedge clk) drive();
      reset_n <= 1'h1;
      for (int k = 0; k < 6000; k++) begin
         @(negedge clk);
         check_all();
         // reset again in mid-run
         if (k == 3000) reset_n <= 1'h0;
         if (k == 3003) reset_n <= 1'h1;
         drive();
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
